// ===== hdl/obd_loader.sv
/*
  Option byte loader: after reset release reads the oscillator and pin
  option byte, the debug option byte and the security identifier from
  flash, decodes them, drives the shared port pin and checks a debugger's
  identifier. Assumes flash answers a read one cycle after the strobe,
  and that register port and debugger logic share core_clk_i.
*/
`timescale 1ns/100ps
module obd_loader
   import obd_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   // flash read port
   output logic flash_rd_o,
   output logic [19:0] flash_addr_o,
   input wire logic [7:0] flash_data_i,
   // register port
   input wire logic [19:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // decoded settings
   output logic cfg_valid_o,
   output logic [4:0] osc_freq_select_o,
   output logic osc_freq_ok_o,
   output logic reset_out_select_n_o,
   output logic debug_enable_bit_o,
   output logic hot_attach_enable_o,
   output logic keep_flash_on_auth_fail_o,
   output logic debug_cfg_bad_o,
   // shared port pin, output only
   output logic shared_port_pin_o,
   output logic shared_port_pin_oe_o,
   output logic reset_status_output_o,
   // debugger identifier check
   input wire logic auth_start_i,
   input wire logic auth_byte_valid_i,
   input wire logic [7:0] auth_byte_i,
   output logic auth_done_o,
   output logic auth_pass_o,
   output logic erase_req_o
);

   // oscillator byte decode, also used for the status register
   function automatic obd_osc_cfg_t osc_decode(input logic [7:0] raw);
      obd_osc_cfg_t c;
      c.freq = raw[OSC_FREQ_HI:0];
      c.rsv_ok = (raw[OSC_RSV_HI:OSC_RSV_LO] == OSC_RSV_VAL);
      c.res_out_n = raw[OSC_RES_SEL];
      c.freq_ok = 1'b0;
      case (raw[OSC_FREQ_HI:0])
         FREQ_24M, FREQ_12M, FREQ_32M, FREQ_16M, FREQ_8M,
         FREQ_4M, FREQ_1M, FREQ_48M, FREQ_64M: c.freq_ok = 1'b1;
         default: c.freq_ok = 1'b0;
      endcase
      return c;
   endfunction

   // debug byte decode; banned patterns fall back to debug disabled
   function automatic obd_dbg_cfg_t dbg_decode(input logic [7:0] raw);
      obd_dbg_cfg_t c;
      logic [2:0] sel;
      sel = {raw[DBG_EN_BIT], raw[DBG_HOT_BIT], raw[DBG_KEEP_BIT]};
      c.dbg_on = 1'b0;
      c.hot_attach = 1'b0;
      c.keep_flash = 1'b0;
      c.bad = (raw[DBG_RSV_HI:DBG_RSV_LO] != DBG_RSV_VAL);
      case (sel)
         3'h0: c.dbg_on = 1'b0;
         3'h4: c.dbg_on = 1'b1;
         3'h5: begin
            c.dbg_on = 1'b1;
            c.keep_flash = 1'b1;
         end
         3'h7: begin
            c.dbg_on = 1'b1;
            c.hot_attach = 1'b1;
            c.keep_flash = 1'b1;
         end
         default: c.bad = 1'b1;
      endcase
      if (c.bad) begin
         c.dbg_on = 1'b0;
         c.hot_attach = 1'b0;
         c.keep_flash = 1'b0;
      end
      return c;
   endfunction

   obd_state_t state_q;
   logic [3:0] issue_idx_q;
   logic rd_d1_q;
   logic [3:0] cap_idx_q;
   logic [7:0] osc_raw_q;
   logic [7:0] dbg_raw_q;
   obd_osc_cfg_t osc_cfg;
   obd_dbg_cfg_t dbg_cfg;
   logic osc_cap;
   logic dbg_cap;
   logic id_wr;
   logic [3:0] id_wr_addr;
   logic port_latch_q;
   logic [3:0] auth_idx_q;
   logic auth_cmp_q;
   logic auth_last_q;
   logic [7:0] auth_byte_q;
   logic auth_miss_q;
   logic auth_fail_q;
   logic [7:0] id_rdata;
   logic auth_miss_now;

   assign osc_cfg = osc_decode(osc_raw_q);
   assign dbg_cfg = dbg_decode(dbg_raw_q);
   assign osc_cap = rd_d1_q && (cap_idx_q == LOAD_OSC_IDX);
   assign dbg_cap = rd_d1_q && (cap_idx_q == LOAD_DBG_IDX);
   assign id_wr = rd_d1_q && (cap_idx_q >= LOAD_ID_FIRST);
   assign id_wr_addr = cap_idx_q - LOAD_ID_FIRST;

   // load sequencer: issue twelve back-to-back reads, then wait for last data
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q <= ST_LOAD;
         issue_idx_q <= 4'h0;
      end else begin
         case (state_q)
            ST_LOAD: begin
               if (issue_idx_q == LOAD_LAST) begin
                  state_q <= ST_DRAIN;
               end else begin
                  issue_idx_q <= issue_idx_q + 4'h1;
               end
            end
            ST_DRAIN: begin
               if (!rd_d1_q) begin
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: state_q <= ST_DONE; // held until the next reset
            default: state_q <= ST_LOAD;
         endcase
      end
   end

   // flash strobe and address come from flops; data arrive one cycle later
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flash_rd_o <= 1'b0;
         flash_addr_o <= 20'h00000;
         rd_d1_q <= 1'b0;
         cap_idx_q <= 4'h0;
      end else begin
         flash_rd_o <= (state_q == ST_LOAD);
         flash_addr_o <= OSC_OPT_ADDR + {16'h0000, issue_idx_q};
         rd_d1_q <= flash_rd_o;
         cap_idx_q <= flash_addr_o[3:0] - OSC_OPT_ADDR[3:0];
      end
   end

   // raw option bytes; written once per load, so the decode stays stable
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         osc_raw_q <= OSC_RAW_RST;
         dbg_raw_q <= DBG_RAW_RST;
      end else begin
         if (osc_cap) begin
            osc_raw_q <= flash_data_i;
         end
         if (dbg_cap) begin
            dbg_raw_q <= flash_data_i;
         end
      end
   end

   // decoded settings, registered so consumers see clean levels
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cfg_valid_o <= 1'b0;
         osc_freq_select_o <= FREQ_24M;
         osc_freq_ok_o <= 1'b0;
         reset_out_select_n_o <= 1'b1;
         debug_enable_bit_o <= 1'b0;
         hot_attach_enable_o <= 1'b0;
         keep_flash_on_auth_fail_o <= 1'b0;
         debug_cfg_bad_o <= 1'b0;
      end else begin
         cfg_valid_o <= (state_q == ST_DONE);
         osc_freq_select_o <= osc_cfg.freq;
         osc_freq_ok_o <= osc_cfg.freq_ok;
         reset_out_select_n_o <= osc_cfg.res_out_n;
         debug_enable_bit_o <= dbg_cfg.dbg_on;
         hot_attach_enable_o <= dbg_cfg.hot_attach;
         keep_flash_on_auth_fail_o <= dbg_cfg.keep_flash;
         debug_cfg_bad_o <= dbg_cfg.bad;
      end
   end

   // shared pin: low in reset and until the load is done, then high in reset-status mode, else the latch
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         shared_port_pin_o <= 1'b0;
         shared_port_pin_oe_o <= 1'b1;
         reset_status_output_o <= 1'b0;
      end else begin
         shared_port_pin_oe_o <= 1'b1;
         if (state_q != ST_DONE) begin
            shared_port_pin_o <= 1'b0; // mode not known yet, keep reset level
            reset_status_output_o <= 1'b0;
         end else if (!osc_cfg.res_out_n) begin
            shared_port_pin_o <= 1'b1;
            reset_status_output_o <= 1'b1;
         end else begin
            shared_port_pin_o <= port_latch_q;
            reset_status_output_o <= 1'b0;
         end
      end
   end

   // port latch register; writable in both modes but ignored in reset-status mode
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         port_latch_q <= 1'b0;
      end else if (reg_wr_i && (reg_addr_i == REG_PORT_LATCH)) begin
         port_latch_q <= reg_wdata_i[0];
      end
   end

   // register reads answer in the next cycle; unmapped addresses read zero
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_addr_i == REG_OSC_OPT) begin
         reg_rdata_o <= osc_raw_q;
      end else if (reg_addr_i == REG_DBG_OPT) begin
         reg_rdata_o <= dbg_raw_q;
      end else if (reg_addr_i == REG_STATUS) begin
         reg_rdata_o <= 8'h00;
         reg_rdata_o[ST_DONE_BIT] <= (state_q == ST_DONE);
         reg_rdata_o[ST_RSV_BAD_BIT] <= !osc_cfg.rsv_ok;
         reg_rdata_o[ST_FREQ_BAD_BIT] <= !osc_cfg.freq_ok;
         reg_rdata_o[ST_DBG_BAD_BIT] <= dbg_cfg.bad;
         reg_rdata_o[ST_AUTH_PASS_BIT] <= auth_pass_o;
         reg_rdata_o[ST_AUTH_FAIL_BIT] <= auth_fail_q;
      end else if (reg_addr_i == REG_PORT_LATCH) begin
         reg_rdata_o <= {7'h00, port_latch_q};
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   // security identifier store, filled during the load
   obd_id_mem u_id_mem (
      .core_clk_i(core_clk_i),
      .wr_en_i(id_wr),
      .wr_addr_i(id_wr_addr),
      .wr_data_i(flash_data_i),
      .rd_addr_i(auth_idx_q),
      .rd_data_o(id_rdata)
   );

   // compare stage: stored byte appears one cycle after its index
   assign auth_miss_now = auth_cmp_q && (auth_byte_q != id_rdata);

   // identifier walk; bytes are taken only once the load has finished
   always_ff @(posedge core_clk_i) begin
      if (srst_i || auth_start_i) begin
         auth_idx_q <= 4'h0;
         auth_cmp_q <= 1'b0;
         auth_last_q <= 1'b0;
         auth_byte_q <= 8'h00;
      end else begin
         auth_cmp_q <= 1'b0;
         auth_last_q <= 1'b0;
         if (auth_byte_valid_i && (state_q == ST_DONE) && (auth_idx_q <= SEC_ID_LAST)) begin
            auth_byte_q <= auth_byte_i;
            auth_cmp_q <= 1'b1;
            auth_last_q <= (auth_idx_q == SEC_ID_LAST);
            auth_idx_q <= auth_idx_q + 4'h1;
         end
      end
   end

   // verdict after the tenth byte; a disabled debugger never passes
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         auth_miss_q <= 1'b0;
         auth_done_o <= 1'b0;
         auth_pass_o <= 1'b0;
         auth_fail_q <= 1'b0;
         erase_req_o <= 1'b0;
      end else begin
         auth_done_o <= 1'b0;
         erase_req_o <= 1'b0;
         // a verdict meeting a restart still lands: the set wins over the clear
         if (auth_last_q) begin
            auth_miss_q <= 1'b0;
            auth_done_o <= 1'b1;
            if (!(auth_miss_q || auth_miss_now) && dbg_cfg.dbg_on) begin
               auth_pass_o <= 1'b1;
               auth_fail_q <= 1'b0;
            end else begin
               auth_pass_o <= 1'b0;
               auth_fail_q <= 1'b1;
               erase_req_o <= dbg_cfg.dbg_on && !dbg_cfg.keep_flash;
            end
         end else if (auth_start_i) begin
            auth_miss_q <= 1'b0;
            auth_pass_o <= 1'b0;
            auth_fail_q <= 1'b0;
         end else if (auth_miss_now) begin
            auth_miss_q <= 1'b1;
         end
      end
   end

endmodule

// ===== hdl/obd_pkg.sv
/*
  Constants and types for the option byte loader: flash locations of the
  two option bytes and the security identifier, field positions, the
  permitted oscillator codes, the register map and the loader states.
  Assumes a byte-wide flash read port and a byte-wide register port.
*/
package obd_pkg;

   localparam int OBD_ADDR_W = 20;
   localparam int OBD_DATA_W = 8;

   // flash locations read after reset release
   localparam logic [19:0] OSC_OPT_ADDR = 20'h000c2;
   localparam logic [19:0] DBG_OPT_ADDR = 20'h000c3;
   localparam logic [19:0] SEC_ID_ADDR = 20'h000c4;
   localparam int SEC_ID_LEN = 10;
   localparam logic [3:0] SEC_ID_LAST = 4'h9;
   localparam logic [3:0] LOAD_LAST = 4'hb;
   localparam logic [3:0] LOAD_ID_FIRST = 4'h2;
   localparam logic [3:0] LOAD_OSC_IDX = 4'h0;
   localparam logic [3:0] LOAD_DBG_IDX = 4'h1;

   // register map on the plain register port
   localparam logic [19:0] REG_OSC_OPT = OSC_OPT_ADDR;
   localparam logic [19:0] REG_DBG_OPT = DBG_OPT_ADDR;
   localparam logic [19:0] REG_STATUS = 20'h00100;
   localparam logic [19:0] REG_PORT_LATCH = 20'h00101;

   // oscillator and pin option byte fields
   localparam int OSC_RSV_HI = 7;
   localparam int OSC_RSV_LO = 6;
   localparam int OSC_RES_SEL = 5;
   localparam int OSC_FREQ_HI = 4;
   localparam logic [1:0] OSC_RSV_VAL = 2'h3;

   // permitted oscillator frequency codes
   localparam logic [4:0] FREQ_24M = 5'h00;
   localparam logic [4:0] FREQ_12M = 5'h01;
   localparam logic [4:0] FREQ_32M = 5'h08;
   localparam logic [4:0] FREQ_16M = 5'h09;
   localparam logic [4:0] FREQ_8M = 5'h0a;
   localparam logic [4:0] FREQ_4M = 5'h0b;
   localparam logic [4:0] FREQ_1M = 5'h0d;
   localparam logic [4:0] FREQ_48M = 5'h10;
   localparam logic [4:0] FREQ_64M = 5'h18;

   // debug option byte fields
   localparam int DBG_EN_BIT = 7;
   localparam int DBG_RSV_HI = 6;
   localparam int DBG_RSV_LO = 2;
   localparam int DBG_HOT_BIT = 1;
   localparam int DBG_KEEP_BIT = 0;
   localparam logic [4:0] DBG_RSV_VAL = 5'h01;

   // raw option byte values before the load: select at one, debug off
   localparam logic [7:0] OSC_RAW_RST = 8'hff;
   localparam logic [7:0] DBG_RAW_RST = 8'h00;

   // status register bit positions
   localparam int ST_DONE_BIT = 0;
   localparam int ST_RSV_BAD_BIT = 1;
   localparam int ST_FREQ_BAD_BIT = 2;
   localparam int ST_DBG_BAD_BIT = 3;
   localparam int ST_AUTH_PASS_BIT = 4;
   localparam int ST_AUTH_FAIL_BIT = 5;

   typedef enum logic [2:0] {
      ST_LOAD = 3'h1,
      ST_DRAIN = 3'h2,
      ST_DONE = 3'h4
   } obd_state_t;

   typedef struct packed {
      logic dbg_on;
      logic hot_attach;
      logic keep_flash;
      logic bad;
   } obd_dbg_cfg_t;

   typedef struct packed {
      logic [4:0] freq;
      logic freq_ok;
      logic rsv_ok;
      logic res_out_n;
   } obd_osc_cfg_t;

endpackage

// ===== hdl/obd_id_mem.sv
/*
  Small synchronous memory for the security identifier bytes.
  Assumes one write port and one read port on the same clock;
  read data come out of a register one cycle after the address.
*/
`timescale 1ns/100ps
module obd_id_mem
   import obd_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic wr_en_i,
   input wire logic [3:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [3:0] rd_addr_i,
   output logic [7:0] rd_data_o
);

   logic [7:0] mem_q [SEC_ID_LEN];

   // write port, no reset: contents are refilled on every load
   always_ff @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem_q[wr_addr_i] <= wr_data_i;
      end
   end

   // registered read; out-of-range index reads zero
   always_ff @(posedge core_clk_i) begin
      if (rd_addr_i <= SEC_ID_LAST) begin
         rd_data_o <= mem_q[rd_addr_i];
      end else begin
         rd_data_o <= 8'h00;
      end
   end

endmodule

// ===== verif/obd_loader_asserts.sv
/*
  Port checker for obd_loader, bound to every instance of it.
  Assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module obd_loader_asserts
   import obd_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic flash_rd_o,
   input wire logic [19:0] flash_addr_o,
   input wire logic [19:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic cfg_valid_o,
   input wire logic [4:0] osc_freq_select_o,
   input wire logic reset_out_select_n_o,
   input wire logic debug_enable_bit_o,
   input wire logic hot_attach_enable_o,
   input wire logic keep_flash_on_auth_fail_o,
   input wire logic debug_cfg_bad_o,
   input wire logic shared_port_pin_o,
   input wire logic shared_port_pin_oe_o,
   input wire logic reset_status_output_o,
   input wire logic auth_done_o,
   input wire logic auth_pass_o,
   input wire logic erase_req_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   // output-only pin is always driven
   property p_oe;
      shared_port_pin_oe_o;
   endproperty
   a_oe: assert property (p_oe) else $error("pin not driven");
   // reset-status mode pins the level high whatever the latch says
   property p_res_mode;
      cfg_valid_o && !reset_out_select_n_o |-> shared_port_pin_o && reset_status_output_o;
   endproperty
   a_res_mode: assert property (p_res_mode) else $error("status pin not high");
   property p_port_mode;
      cfg_valid_o && reset_out_select_n_o |-> !reset_status_output_o;
   endproperty
   a_port_mode: assert property (p_port_mode) else $error("status in port mode");
   // loading starts with the oscillator byte, then the debug byte
   property p_first_rd;
      $rose(flash_rd_o) |-> flash_addr_o == OSC_OPT_ADDR ##1 flash_addr_o == DBG_OPT_ADDR;
   endproperty
   a_first_rd: assert property (p_first_rd) else $error("load order wrong");
   // past reset excluded: a reset in mid-load also drops the strobe
   property p_last_rd;
      $fell(flash_rd_o) && !$past(srst_i) |-> $past(flash_addr_o) == SEC_ID_ADDR + 20'h9;
   endproperty
   a_last_rd: assert property (p_last_rd) else $error("last id byte not read");
   property p_valid;
      $fell(flash_rd_o) && !$past(srst_i) |-> ##[1:3] cfg_valid_o;
   endproperty
   a_valid: assert property (p_valid) else $error("settings not valid after load");
   property p_hold;
      cfg_valid_o |=> cfg_valid_o && $stable(osc_freq_select_o) && $stable(debug_enable_bit_o);
   endproperty
   a_hold: assert property (p_hold) else $error("settings moved");
   property p_dbg_legal;
      cfg_valid_o |-> {debug_enable_bit_o, hot_attach_enable_o, keep_flash_on_auth_fail_o}
         inside {3'b000, 3'b100, 3'b101, 3'b111} && !(debug_cfg_bad_o && debug_enable_bit_o);
   endproperty
   a_dbg_legal: assert property (p_dbg_legal) else $error("debug decode illegal");
   property p_erase;
      erase_req_o |-> auth_done_o && !auth_pass_o && debug_enable_bit_o && !keep_flash_on_auth_fail_o;
   endproperty
   a_erase: assert property (p_erase) else $error("erase without cause");
   property p_rd_osc;
      reg_rd_i && reg_addr_i == REG_OSC_OPT && cfg_valid_o |=>
         reg_rdata_o[4:0] == osc_freq_select_o && reg_rdata_o[5] == reset_out_select_n_o;
   endproperty
   a_rd_osc: assert property (p_rd_osc) else $error("option read mismatch");
   property p_rd_idle;
      !reg_rd_i |=> reg_rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule

bind obd_loader obd_loader_asserts u_chk (.core_clk_i, .srst_i, .flash_rd_o, .flash_addr_o, .reg_addr_i,
   .reg_rd_i, .reg_rdata_o, .cfg_valid_o, .osc_freq_select_o, .reset_out_select_n_o, .debug_enable_bit_o,
   .hot_attach_enable_o, .keep_flash_on_auth_fail_o, .debug_cfg_bad_o, .shared_port_pin_o,
   .shared_port_pin_oe_o, .reset_status_output_o, .auth_done_o, .auth_pass_o, .erase_req_o);

// ===== verif/obd_flash_model.sv
/*
  Flash array model holding the option bytes and the identifier.
  Assumes the image only changes while the loader is in reset.
*/
`timescale 1ns/100ps
module obd_flash_model
   import obd_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic flash_rd_i,
   input wire logic [19:0] flash_addr_i,
   input wire logic [95:0] image_i,
   output logic [7:0] flash_data_o
);
   logic [19:0] idx;

   assign idx = flash_addr_i - OSC_OPT_ADDR;

   // answer a cycle after the strobe; idle cycles toggle so stale data never looks valid
   initial flash_data_o = 8'h5a;
   always @(posedge core_clk_i) begin
      if (flash_rd_i && idx < 20'd12) begin
         flash_data_o <= image_i[8*idx[3:0] +: 8];
      end else begin
         flash_data_o <= ~flash_data_o;
      end
   end
endmodule

// ===== verif/obd_loader_tb.sv
/*
  Self-checking bench for obd_loader with a reference decode in integers.
  Assumes the flash model answers one cycle after each read strobe.
*/
`timescale 1ns/100ps
module obd_loader_tb
   import obd_pkg::*;
;
   logic core_clk_i = 0;
   logic srst_i = 1;
   logic reg_wr_i = 0;
   logic reg_rd_i = 0;
   logic auth_start_i = 0;
   logic auth_byte_valid_i = 0;
   logic [19:0] reg_addr_i = '0;
   logic [7:0] reg_wdata_i = '0;
   logic [7:0] auth_byte_i = '0;
   logic [7:0] flash_data_i;
   logic [7:0] reg_rdata_o;
   logic [19:0] flash_addr_o;
   logic [4:0] osc_freq_select_o;
   logic flash_rd_o, cfg_valid_o, osc_freq_ok_o, reset_out_select_n_o, debug_enable_bit_o;
   logic hot_attach_enable_o, keep_flash_on_auth_fail_o, debug_cfg_bad_o, shared_port_pin_o;
   logic shared_port_pin_oe_o, reset_status_output_o, auth_done_o, auth_pass_o, erase_req_o;
   logic [95:0] image = '0;
   int miscompares = 0;
   int compares = 0;
   logic [4:0] codes [9] = '{FREQ_24M, FREQ_12M, FREQ_32M, FREQ_16M, FREQ_8M, FREQ_4M, FREQ_1M,
      FREQ_48M, FREQ_64M};
   logic [7:0] dbgs [5] = '{8'h04, 8'h84, 8'h85, 8'h87, 8'h05};

   obd_loader u_dut (.core_clk_i, .srst_i, .flash_rd_o, .flash_addr_o, .flash_data_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cfg_valid_o, .osc_freq_select_o, .osc_freq_ok_o,
      .reset_out_select_n_o, .debug_enable_bit_o, .hot_attach_enable_o, .keep_flash_on_auth_fail_o,
      .debug_cfg_bad_o, .shared_port_pin_o, .shared_port_pin_oe_o, .reset_status_output_o, .auth_start_i,
      .auth_byte_valid_i, .auth_byte_i, .auth_done_o, .auth_pass_o, .erase_req_o);
   obd_flash_model u_flash (.core_clk_i, .flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o),
      .image_i(image), .flash_data_o(flash_data_i));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   // data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1 check(reg_rdata_o, exp);
   endtask

   // 200 MHz clock
   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // watchdog, far beyond fourteen loads with their traffic
   initial begin
      repeat (20000) @(posedge core_clk_i);
      miscompares++;
      conclude();
   end

   // main sequence: one load per pass, codes and debug modes from tables, then random ones
   initial begin
      logic [7:0] osc, dbg, b;
      int ok, legal, en, hot, keep, good, n, pass;
      void'($urandom(32'h88d15ff9));
      for (int i = 0; i < 14; i++) begin
         // odd passes keep the select at one, as a package without the pin should
         osc = {2'b11, 1'(i), (i < 9) ? codes[i] : 5'($urandom)};
         if (i == 12) begin
            osc[7:6] = 2'b10; // broken reserved bits are only flagged
         end
         dbg = (i < 10) ? dbgs[i % 5] : 8'($urandom);
         ok = 0;
         foreach (codes[k]) begin
            if (codes[k] == osc[4:0]) ok = 1;
         end
         en = dbg[7];
         hot = dbg[1];
         keep = dbg[0];
         legal = (dbg[6:2] == DBG_RSV_VAL) && (hot ? (en && keep) : (en || !keep));
         if (!legal) begin
            en = 0;
            hot = 0;
            keep = 0;
         end
         @(posedge core_clk_i);
         srst_i <= 1'b1;
         image = {$urandom, $urandom, 16'($urandom), 16'h0000} | {80'h0, dbg, osc};
         repeat (12) @(posedge core_clk_i);
         srst_i <= 1'b0;
         #1 check(shared_port_pin_o, 1'b0);
         n = 0;
         while (cfg_valid_o !== 1'b1 && n < 40) begin
            @(posedge core_clk_i);
            #1 n++;
         end
         check(cfg_valid_o, 1'b1);
         check(osc_freq_select_o, osc[4:0]);
         check(osc_freq_ok_o, ok);
         check(reset_out_select_n_o, osc[5]);
         check({debug_enable_bit_o, hot_attach_enable_o, keep_flash_on_auth_fail_o},
            {en[0], hot[0], keep[0]});
         check(debug_cfg_bad_o, !legal);
         for (int k = 0; k < 2; k++) begin
            b = {7'h00, 1'(k + i)};
            reg_wr(REG_PORT_LATCH, b);
            repeat (2) @(posedge core_clk_i);
            #1 check(shared_port_pin_o, osc[5] ? b[0] : 1'b1);
            check(reset_status_output_o, !osc[5]);
            rd_chk(REG_PORT_LATCH, b);
         end
         rd_chk(REG_OSC_OPT, osc);
         reg_wr(REG_OSC_OPT, ~osc);
         rd_chk(REG_OSC_OPT, osc);
         rd_chk(REG_DBG_OPT, dbg);
         rd_chk(20'h00200, 8'h00);
         // identifier check, one byte spoiled on some passes
         good = (i % 3) != 0;
         @(posedge core_clk_i);
         auth_start_i <= 1'b1;
         for (int j = 0; j < 10; j++) begin
            @(posedge core_clk_i);
            auth_start_i <= 1'b0;
            auth_byte_valid_i <= 1'b1;
            auth_byte_i <= image[16 + 8*j +: 8] ^ ((good || j != 4) ? 8'h00 : 8'h10);
         end
         @(posedge core_clk_i);
         auth_byte_valid_i <= 1'b0;
         n = 0;
         #1 while (auth_done_o !== 1'b1 && n < 8) begin
            @(posedge core_clk_i);
            #1 n++;
         end
         pass = en && good;
         check(n, 1);
         check(auth_pass_o, pass);
         check(erase_req_o, !pass && en && !keep);
         rd_chk(REG_STATUS, {2'b00, !pass, pass[0], !legal, !ok, osc[7:6] != 2'b11, 1'b1});
      end
      conclude();
   end
endmodule
